// >>> design/panel_timing_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: One pixel clock period equals two cycles of the block clock.
// Notes:   Register offsets are byte offsets inside the register window.
`ifndef PANEL_TIMING_MAP_SVH
`define PANEL_TIMING_MAP_SVH

`define REG_WINDOW_TOP      12'hfff
`define REG_REVISION        5'h00
`define REG_MODE            5'h01
`define REG_HORIZ_DISPLAY   5'h04
`define REG_VERT_DISP_LOW   5'h05
`define REG_VERT_DISP_HIGH  5'h06
`define REG_DATA_READY_STROBE_POSITION   5'h07
`define REG_HORIZ_NON_DISP  5'h08
`define REG_VERT_NON_DISP   5'h0a
`define REG_STATUS          5'h1f

`define MODE_BIT_TFT        7
`define MODE_BIT_DUAL       6
`define MODE_BIT_COLOR      5
`define MODE_BIT_LINE_POL   4
`define MODE_BIT_FRAME_POL  3
`define MODE_BIT_MASK_SHIFT 2

`define REG_RESET_VALUE     8'h00
// The product and revision codes below are arbitrary values.
`define PRODUCT_ID_VALUE    6'h15
`define REVISION_ID_VALUE   2'h1

`define LINE_PULSE_WIDTH    12'h009
`define FRAME_TO_LINE_LEAD  12'h012
`define DATA_READY_STROBE_TO_LINE_BASE   12'h010
`define PASSIVE_LINE_RISE   12'h011
`define PASSIVE_LINE_FALL   12'h01a
`define HORIZONTAL_NON_DISPLAY_PERIOD_BASE           5'h04

`define PIXEL_WIDTH         12
`define FIFO_DEPTH          8

`endif

// >>> design/panel_timing_pkg.sv
// Purpose: Types shared by the panel timing generator.
// Assumes: Nothing beyond the map header.
// Notes:   Widths follow the map header.
package panel_timing_pkg;
  typedef enum logic {
    PANEL_PASSIVE,
    PANEL_TFT
  } panel_mode_e;
  typedef logic [11:0] pixel_t;
  typedef logic [11:0] hcount_t;
  typedef logic [10:0] vcount_t;
  typedef logic [12:0] fcount_t;
endpackage

// >>> design/pixel_fifo.sv
// Purpose: Small first-in first-out buffer for pixel words.
// Assumes: Both sides run on the same clock.
// Notes:   Ready and valid follow the fill count directly.
`timescale 1ns/1ns
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push;
  wire              pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end
endmodule // pixel_fifo
`default_nettype wire

// >>> design/panel_timing_gen.sv
// Purpose: Panel timing generator with shift clock, line and frame pulses,
//          data-ready strobe and pixel data, configured over Wishbone.
// Assumes: clock_in runs at twice the pixel rate; pixel words arrive from
//          a source on its own strobe clock, which is sampled here.
// Notes:   All panel outputs other than the shift clock change only at clock_in edges where the shift clock rises or, when masked, would rise.
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "panel_timing_map.svh"
module panel_timing_gen
  import panel_timing_pkg::*;
#(
  parameter logic [5:0] PRODUCT_ID  = `PRODUCT_ID_VALUE,
  parameter logic [1:0] REVISION_ID = `REVISION_ID_VALUE
) (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [16:0] wb_adr_in,
  input  wire logic        wb_sel_in,
  input  wire logic [7:0]  wb_dat_in,
  output logic      [7:0]  wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        src_clk_in,
  input  wire logic        src_valid_in,
  input  wire logic [11:0] src_data_in,
  output logic             src_ready_out,
  output logic             pixel_shift_clock_out,
  output logic             line_pulse_out,
  output logic             frame_pulse_out,
  output logic             data_ready_strobe_out,
  output logic      [11:0] panel_pixel_data_out
);

  // Multiplies a field by eight pixel clocks.
  function automatic hcount_t times8(input logic [8:0] field);
    times8 = hcount_t'({field, 3'b000});
  endfunction

  // Distance from a start position to the counter, modulo the line length.
  function automatic hcount_t line_offset(input hcount_t pos,
                                          input hcount_t start,
                                          input hcount_t len);
    line_offset = (pos >= start) ? pos - start : pos + len - start;
  endfunction

  // Wraps a position that runs past the end of the line.
  function automatic hcount_t line_wrap(input hcount_t pos,
                                        input hcount_t len);
    line_wrap = (pos >= len) ? pos - len : pos;
  endfunction

  // Registers.
  logic [7:0] mode_reg;
  logic [7:0] horiz_display_reg;
  logic [7:0] vert_disp_low_reg;
  logic [7:0] vert_disp_high_reg;
  logic [7:0] data_ready_strobe_position_reg;
  logic [7:0] horiz_non_disp_reg;
  logic [7:0] vert_non_disp_reg;
  logic [7:0] rd_data_reg;
  logic       ack_reg;

  // Bus decode.
  wire        bus_request;
  wire        in_window;
  wire [4:0]  reg_index;
  wire        write_strobe;
  wire [7:0]  read_value;

  assign bus_request  = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign in_window    = (wb_adr_in[16:5] == `REG_WINDOW_TOP);
  assign reg_index    = wb_adr_in[4:0];
  assign write_strobe = bus_request & wb_we_in & wb_sel_in & in_window;

  // Source synchroniser and edge detector.
  logic [13:0] src_sync1_reg;
  logic [13:0] src_sync2_reg;
  logic        src_clk_prev_reg;
  wire         src_push;
  wire         fifo_out_valid;
  wire         fifo_pop;
  pixel_t      fifo_out_data;

  assign src_push = src_sync2_reg[13] & ~src_clk_prev_reg & src_sync2_reg[12];

  pixel_fifo #(
    .WIDTH (`PIXEL_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (src_push),
    .in_ready_out  (src_ready_out),
    .in_data_in    (src_sync2_reg[11:0]),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // Timing state.
  logic        phase_reg;
  hcount_t     hcount_reg;
  vcount_t     vcount_reg;
  fcount_t     frame_count_reg;
  logic        frame_active_reg;
  logic        shift_reg;
  logic        line_reg;
  logic        frame_reg;
  logic        data_ready_strobe_reg;
  pixel_t      pixel_reg;

  panel_mode_e panel_mode;
  wire         tick;
  wire         color_passive;
  wire         shift_masked;
  hcount_t     hdp_len;
  hcount_t     horizontal_non_display_period_len;
  hcount_t     horizontal_non_display_period_field8;
  hcount_t     tft_line_len;
  hcount_t     disp_len;
  hcount_t     line_len;
  hcount_t     line_start_raw;
  hcount_t     line_start;
  hcount_t     frame_start;
  vcount_t     vdp_lines;
  vcount_t     frame_lines;
  wire         line_end;
  wire         frame_end;
  wire         in_h_display;
  wire         in_v_display;
  wire         display_now;
  wire         line_asserted;
  wire         frame_trigger;
  wire         frame_done;
  wire         frame_asserted;
  wire         line_level;
  wire         frame_level;
  wire         shift_enable;

  assign panel_mode    = mode_reg[`MODE_BIT_TFT] ? PANEL_TFT : PANEL_PASSIVE;
  assign tick          = phase_reg;
  assign color_passive = (panel_mode == PANEL_PASSIVE)
                       & mode_reg[`MODE_BIT_COLOR];

  assign hdp_len      = times8({2'b00, horiz_display_reg[6:0]} + 9'h001);
  assign horizontal_non_display_period_len     = times8({4'h0, horiz_non_disp_reg[4:0]}
                      + {4'h0, `HORIZONTAL_NON_DISPLAY_PERIOD_BASE});
  assign tft_line_len = hdp_len + horizontal_non_display_period_len;
  assign disp_len     = (panel_mode == PANEL_TFT) ? hdp_len
                      : {hdp_len[10:0], 1'b0};
  assign line_len     = (panel_mode == PANEL_TFT) ? tft_line_len
                      : {tft_line_len[10:0], 1'b0};
  assign horizontal_non_display_period_field8  = times8({4'h0, horiz_non_disp_reg[4:0]});

  // The line pulse start follows the data-ready fall in TFT mode and the
  // last shift edge of the display period in passive mode.
  assign line_start_raw = (panel_mode == PANEL_TFT)
    ? hdp_len + times8({4'h0, data_ready_strobe_position_reg[4:0]})
      + `DATA_READY_STROBE_TO_LINE_BASE
    : disp_len + {horizontal_non_display_period_field8[10:0], 1'b0}
      + `PASSIVE_LINE_RISE;
  assign line_start  = line_wrap(line_start_raw, line_len);
  assign frame_start = line_wrap(line_start + `FRAME_TO_LINE_LEAD,
                                 line_len);

  assign vdp_lines   = {1'b0, vert_disp_high_reg[1:0], vert_disp_low_reg}
                     + 11'h001;
  assign frame_lines = vdp_lines + {4'h0, vert_non_disp_reg[6:0]};

  assign line_end     = (hcount_reg >= line_len - 12'h001);
  assign frame_end    = (vcount_reg >= frame_lines - 11'h001);
  assign in_h_display = (hcount_reg < disp_len);
  assign in_v_display = (vcount_reg < vdp_lines);
  assign display_now  = in_h_display & in_v_display;

  // Width nine covers both the TFT low time and the passive rise-to-fall.
  assign line_asserted = line_offset(hcount_reg, line_start, line_len)
                       < `LINE_PULSE_WIDTH;

  assign frame_trigger  = frame_end & (hcount_reg == frame_start);
  assign frame_done     = (frame_count_reg
                        >= {line_len, 1'b0} - 13'h0001);
  assign frame_asserted = frame_active_reg | frame_trigger;

  // TFT levels follow the polarity bits; passive pulses are active high.
  assign line_level  = (panel_mode == PANEL_TFT)
                     ? (mode_reg[`MODE_BIT_LINE_POL] ? line_asserted
                                                     : ~line_asserted)
                     : line_asserted;
  assign frame_level = (panel_mode == PANEL_TFT)
                     ? (mode_reg[`MODE_BIT_FRAME_POL] ? frame_asserted
                                                      : ~frame_asserted)
                     : frame_asserted;

  assign shift_masked = color_passive | mode_reg[`MODE_BIT_MASK_SHIFT];
  assign shift_enable = ~shift_masked | display_now;
  assign fifo_pop     = tick & display_now & fifo_out_valid;

  // Register read multiplexer.
  assign read_value =
      (!in_window) ? 8'h00 :
      (reg_index == `REG_REVISION)       ? {PRODUCT_ID, REVISION_ID} :
      (reg_index == `REG_MODE)           ? mode_reg :
      (reg_index == `REG_HORIZ_DISPLAY)  ? horiz_display_reg :
      (reg_index == `REG_VERT_DISP_LOW)  ? vert_disp_low_reg :
      (reg_index == `REG_VERT_DISP_HIGH) ? vert_disp_high_reg :
      (reg_index == `REG_DATA_READY_STROBE_POSITION)  ? data_ready_strobe_position_reg :
      (reg_index == `REG_HORIZ_NON_DISP) ? horiz_non_disp_reg :
      (reg_index == `REG_VERT_NON_DISP)  ? vert_non_disp_reg :
      (reg_index == `REG_STATUS)
        ? {5'h00, frame_active_reg, ~fifo_out_valid, in_v_display} :
      8'h00;

  assign wb_ack_out            = ack_reg;
  assign wb_dat_out            = rd_data_reg;
  assign pixel_shift_clock_out = shift_reg;
  assign line_pulse_out        = line_reg;
  assign frame_pulse_out       = frame_reg;
  assign data_ready_strobe_out = data_ready_strobe_reg;
  assign panel_pixel_data_out  = pixel_reg;

  // Wishbone slave; an access outside the window is acknowledged with zero.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg     <= 1'b0;
      rd_data_reg <= 8'h00;
    end else begin
      ack_reg <= bus_request;
      if (bus_request) begin
        rd_data_reg <= read_value;
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg           <= `REG_RESET_VALUE;
      horiz_display_reg  <= `REG_RESET_VALUE;
      vert_disp_low_reg  <= `REG_RESET_VALUE;
      vert_disp_high_reg <= `REG_RESET_VALUE;
      data_ready_strobe_position_reg  <= `REG_RESET_VALUE;
      horiz_non_disp_reg <= `REG_RESET_VALUE;
      vert_non_disp_reg  <= `REG_RESET_VALUE;
    end else if (write_strobe) begin
      if (reg_index == `REG_MODE) begin
        mode_reg <= wb_dat_in;
      end else if (reg_index == `REG_HORIZ_DISPLAY) begin
        horiz_display_reg <= {1'b0, wb_dat_in[6:0]};
      end else if (reg_index == `REG_VERT_DISP_LOW) begin
        vert_disp_low_reg <= wb_dat_in;
      end else if (reg_index == `REG_VERT_DISP_HIGH) begin
        vert_disp_high_reg <= {6'h00, wb_dat_in[1:0]};
      end else if (reg_index == `REG_DATA_READY_STROBE_POSITION) begin
        data_ready_strobe_position_reg <= {3'h0, wb_dat_in[4:0]};
      end else if (reg_index == `REG_HORIZ_NON_DISP) begin
        horiz_non_disp_reg <= {3'h0, wb_dat_in[4:0]};
      end else if (reg_index == `REG_VERT_NON_DISP) begin
        vert_non_disp_reg <= {1'b0, wb_dat_in[6:0]};
      end
    end
  end

  // Two flip-flops in front of the edge detector.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_sync1_reg    <= '0;
      src_sync2_reg    <= '0;
      src_clk_prev_reg <= 1'b0;
    end else begin
      src_sync1_reg    <= {src_clk_in, src_valid_in, src_data_in};
      src_sync2_reg    <= src_sync1_reg;
      src_clk_prev_reg <= src_sync2_reg[13];
    end
  end

  // The horizontal counter advances once per pixel clock, the vertical counter once per line.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_reg  <= 1'b0;
      hcount_reg <= '0;
      vcount_reg <= '0;
    end else begin
      phase_reg <= ~phase_reg;
      if (tick) begin
        hcount_reg <= line_end ? '0 : hcount_reg + 12'h001;
        if (line_end) begin
          vcount_reg <= frame_end ? '0 : vcount_reg + 11'h001;
        end
      end
    end
  end

  // Frame pulse runs for exactly two line lengths once triggered.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_active_reg <= 1'b0;
      frame_count_reg  <= '0;
    end else if (tick) begin
      if (frame_trigger) begin
        frame_active_reg <= 1'b1;
        frame_count_reg  <= 13'h0001;
      end else if (frame_active_reg && frame_done) begin
        frame_active_reg <= 1'b0;
        frame_count_reg  <= '0;
      end else if (frame_active_reg) begin
        frame_count_reg <= frame_count_reg + 13'h0001;
      end
    end
  end

  // Shift clock rises with every launch unless masked, and falls one cycle later, so
  // every launched output is stable one cycle each side of the fall.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift_reg <= 1'b0;
    end else begin
      shift_reg <= tick & shift_enable;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_reg  <= 1'b1;
      frame_reg <= 1'b1;
      data_ready_strobe_reg  <= 1'b0;
      pixel_reg <= '0;
    end else if (tick) begin
      line_reg  <= line_level;
      frame_reg <= frame_level;
      data_ready_strobe_reg  <= display_now;
      pixel_reg <= fifo_pop ? fifo_out_data : '0;
    end
  end

endmodule // panel_timing_gen
`default_nettype wire

// >>> tb/panel_timing_gen_sva.sv
// Purpose: Port-level checks on the panel timing generator.
// Assumes: One pixel clock is two cycles of clock_in.
// Notes:   Width, mask and shift-run checks wait until configuration writes have settled.
`timescale 1ns/1ns
`default_nettype none
module panel_timing_gen_sva (
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [16:0] wb_adr_in,
  input wire logic [7:0]  wb_dat_in,
  input wire logic [7:0]  wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        pixel_shift_clock_out,
  input wire logic        line_pulse_out,
  input wire logic        frame_pulse_out,
  input wire logic        data_ready_strobe_out,
  input wire logic [11:0] panel_pixel_data_out
);
  logic [7:0]  mode_reg;
  logic [6:0]  hdp_reg;
  logic [10:0] quiet_reg;
  logic [5:0]  high_reg;
  logic [11:0] data_ready_strobe_reg;
  wire         wr_hit = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out;
  wire         tft = mode_reg[7];
  wire         settled = quiet_reg == 11'h7ff;
  wire         masked = (!tft && mode_reg[5]) || mode_reg[2];
  wire         line_tft = line_pulse_out == mode_reg[4];
  wire         line_act = tft ? line_tft : line_pulse_out;
  wire  [11:0] data_ready_strobe_len = ({5'h00, hdp_reg} + 12'h001) << (tft ? 4 : 5);
  wire         shift = pixel_shift_clock_out;
  wire         data_ready_strobe = data_ready_strobe_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Shadows the mode and display length fields from bus writes.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg  <= 8'h00;
      hdp_reg   <= 7'h00;
      quiet_reg <= 11'h000;
      high_reg  <= 6'h00;
      data_ready_strobe_reg  <= 12'h000;
    end else begin
      if (wr_hit && wb_adr_in == 17'h1ffe1) mode_reg <= wb_dat_in;
      if (wr_hit && wb_adr_in == 17'h1ffe4) hdp_reg <= wb_dat_in[6:0];
      quiet_reg <= wr_hit ? 11'h000 : quiet_reg + {10'h000, !settled};
      high_reg  <= line_act ? high_reg + 6'h01 : 6'h00;
      data_ready_strobe_reg  <= data_ready_strobe ? data_ready_strobe_reg + 12'h001 : 12'h000;
    end
  end
  property p_shift_high; shift |=> !shift; endproperty
  a_shift_high: assert property (p_shift_high)
    else $error("shift clock high longer than one cycle");
  property p_shift_run; settled && tft && !mode_reg[2] && !shift |=> shift;
  endproperty
  a_shift_run: assert property (p_shift_run)
    else $error("shift clock low longer than one cycle");
  property p_hold; $fell(shift) |-> $stable(panel_pixel_data_out) &&
    $stable(data_ready_strobe) && $stable(line_pulse_out) && $stable(frame_pulse_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("panel output changed at shift falling edge");
  property p_line_width; settled && $fell(line_act) |-> high_reg == 6'd18;
  endproperty
  a_line_width: assert property (p_line_width)
    else $error("line pulse width wrong");
  property p_data_ready_strobe_width; settled && $fell(data_ready_strobe) |-> data_ready_strobe_reg == data_ready_strobe_len;
  endproperty
  a_data_ready_strobe_width: assert property (p_data_ready_strobe_width)
    else $error("data ready width wrong");
  property p_mask; settled && masked && !data_ready_strobe |-> !shift; endproperty
  a_mask: assert property (p_mask)
    else $error("shift clock not masked");
  property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered in one cycle");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  property p_unmapped;
    wb_ack_out && !wb_we_in && wb_adr_in < 17'h1ffe0 |-> wb_dat_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("read outside register window not zero");
endmodule // panel_timing_gen_sva
bind panel_timing_gen panel_timing_gen_sva sva_u (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .pixel_shift_clock_out(pixel_shift_clock_out),
  .line_pulse_out(line_pulse_out), .frame_pulse_out(frame_pulse_out),
  .data_ready_strobe_out(data_ready_strobe_out),
  .panel_pixel_data_out(panel_pixel_data_out)
);
`default_nettype wire

// >>> tb/pixel_source.sv
// Purpose: Pixel source on its own strobe clock.
// Assumes: Strobe period is 160 ns; the strobe stands still between bursts.
// Notes:   Words count up from 12'ha50; idle data is the inverse of the last.
`timescale 1ns/1ns
`default_nettype none
module pixel_source (
  input  wire logic        start_in,
  input  wire logic [3:0]  count_in,
  output logic             src_clk_out,
  output logic             src_valid_out,
  output logic      [11:0] src_data_out
);
  initial begin
    src_clk_out = 1'b0;
    src_valid_out = 1'b0;
    src_data_out = 12'h5af;
  end
  // Data and valid rise with the strobe and stand for the whole period.
  always @(posedge start_in) begin
    for (int i = 0; i < count_in; i++) begin
      src_data_out = 12'ha50 + i[11:0];
      src_valid_out = 1'b1;
      src_clk_out = 1'b1;
      #80 src_clk_out = 1'b0;
      #80;
    end
    src_valid_out = 1'b0;
    src_data_out = ~src_data_out;
  end
endmodule // pixel_source
`default_nettype wire

// >>> tb/panel_timing_gen_bench.sv
// Purpose: Self-checking bench for the panel timing generator.
// Assumes: Timing fields 04h=01, 08h=1f, 07h=02, three lines a frame.
// Notes:   TFT line is 296 pixel clocks, 592 cycles of clock_in; a passive line is twice that.
`timescale 1ns/1ns
`default_nettype none
`include "panel_timing_map.svh"
module panel_timing_gen_bench;
  logic        clock_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [16:0] adr = 17'h00000;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  rd;
  logic        ack;
  logic        sclk;
  logic        svalid;
  logic [11:0] sdata;
  logic        sready;
  logic        shift;
  logic        line;
  logic        frame;
  logic        data_ready_strobe;
  logic [11:0] pix;
  logic        start = 1'b0;
  logic        shift_prev = 1'b0;
  logic [7:0]  q;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc_n = 0;
  int          last_fall = 0;
  int          a, b, c, d;
  panel_timing_gen dut_u (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(1'b1),
    .wb_dat_in(wd), .wb_dat_out(rd), .wb_ack_out(ack), .src_clk_in(sclk),
    .src_valid_in(svalid), .src_data_in(sdata), .src_ready_out(sready),
    .pixel_shift_clock_out(shift), .line_pulse_out(line),
    .frame_pulse_out(frame), .data_ready_strobe_out(data_ready_strobe),
    .panel_pixel_data_out(pix)
  );
  pixel_source src_u (
    .start_in(start), .count_in(4'h9), .src_clk_out(sclk),
    .src_valid_out(svalid), .src_data_out(sdata)
  );
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) cyc_n <= cyc_n + 1;
  always @(negedge clock_in) begin
    shift_prev <= shift;
    if (shift_prev === 1'b1 && shift === 1'b0) last_fall <= cyc_n;
  end
  task print_verdict;
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task timeout(input string name);
    chk(name, 0, 1);
    print_verdict();
  endtask
  task wb(input logic w, input logic [16:0] ad, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wd <= dat;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) timeout("bus_timeout");
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? line : (s == 1 ? frame : data_ready_strobe);
  endfunction
  task wait_sig(input int s, input logic v, output int t);
    int n;
    n = 0;
    @(negedge clock_in);
    while (sig(s) !== ~v && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    while (sig(s) !== v && n < 5000) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 5000) timeout("panel_timeout");
    t = cyc_n;
  endtask
  task set_mode(input logic [7:0] m);
    wb(1'b1, 17'h1ffe1, m);
    repeat (2500) @(posedge clock_in);
  endtask
  task regs_check;
    wb(1'b0, 17'h1ffe0, 8'h00);
    chk("revision", q, {`PRODUCT_ID_VALUE, `REVISION_ID_VALUE});
    wb(1'b0, 17'h1ffe1, 8'h00);
    chk("mode_reset", q, `REG_RESET_VALUE);
    wb(1'b0, 17'h1ffff, 8'h00);
    chk("fifo_empty", q & 8'h02, 8'h02);
    wb(1'b1, 17'h1ffe0, 8'hff);
    wb(1'b0, 17'h1ffe0, 8'h00);
    chk("revision_ro", q, {`PRODUCT_ID_VALUE, `REVISION_ID_VALUE});
    wb(1'b1, 17'h1ffe4, 8'hff);
    wb(1'b0, 17'h1ffe4, 8'h00);
    chk("hdp_bits", q, 8'h7f);
    wb(1'b0, 17'h1ffdf, 8'h00);
    chk("unmapped", q, 8'h00);
    wb(1'b1, 17'h00001, 8'hff);
    wb(1'b0, 17'h1ffe1, 8'h00);
    chk("mode_alias", q, 8'h00);
  endtask
  task tft_timing;
    set_mode(8'h80);
    wait_sig(0, 0, a);
    wait_sig(0, 0, b);
    chk("line_period", b - a, 592);
    wait_sig(0, 1, c);
    chk("line_width", c - b, 18);
    wait_sig(2, 1, a);
    wait_sig(2, 0, b);
    chk("data_ready_strobe_width", b - a, 32);
    wait_sig(0, 0, c);
    chk("data_ready_strobe_to_line", c - b, 64);
    wait_sig(1, 0, a);
    wait_sig(0, 0, b);
    chk("frame_lead", b - a, 556);
    wait_sig(1, 1, c);
    chk("frame_width", c - a, 1184);
    wait_sig(1, 0, d);
    chk("frame_period", d - a, 1776);
  endtask
  task polarity;
    set_mode(8'h9c);
    wait_sig(0, 1, a);
    wait_sig(0, 0, b);
    chk("line_high", b - a, 18);
    wait_sig(1, 1, a);
    wait_sig(1, 0, b);
    chk("frame_high", b - a, 1184);
  endtask
  task passive;
    set_mode(8'h60);
    repeat (3) begin
      wait_sig(0, 1, a);
      c = a - last_fall;
      if (c < 1100) break;
    end
    wait_sig(0, 0, b);
    wait_sig(0, 1, d);
    chk("shift_to_rise", c >= 1025 && c <= 1027, 1);
    chk("shift_to_fall", b - a + c >= 1043 && b - a + c <= 1045, 1);
    chk("passive_period", d - a, 1184);
  endtask
  task fifo_data;
    int n;
    n = 0;
    set_mode(8'h80);
    wait_sig(2, 0, a);
    @(posedge clock_in);
    start <= 1'b1;
    @(posedge clock_in);
    start <= 1'b0;
    while (sready !== 1'b0 && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    chk("fifo_full", sready, 0);
    wait_sig(2, 1, a);
    for (int i = 0; i < 17; i++) begin
      chk("pixel", pix, i < 8 ? 12'ha50 + i : 12'h000);
      chk("data_ready_strobe", data_ready_strobe, i < 16);
      repeat (2) @(negedge clock_in);
    end
    chk("fifo_drained", sready, 1);
  endtask
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    regs_check();
    wb(1'b1, 17'h1ffe4, 8'h01);
    wb(1'b1, 17'h1ffe8, 8'h1f);
    wb(1'b1, 17'h1ffe7, 8'h02);
    wb(1'b1, 17'h1ffe5, 8'h01);
    wb(1'b1, 17'h1ffe6, 8'h00);
    wb(1'b1, 17'h1ffea, 8'h01);
    tft_timing();
    polarity();
    passive();
    fifo_data();
    print_verdict();
  end
endmodule // panel_timing_gen_bench
`default_nettype wire
